// ===== hw/gpio_pkg.sv
// Purpose: Shared constants for the dual general-purpose port block.
// Assumes: APB with 32-bit data; each register one aligned word.
// Notes:   Offsets are byte addresses.
package gpio_pkg;
    // =====================================================================
    // Bus geometry
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int PORT_A_W = 6;
    localparam int PORT_B_W = 8;

    // =====================================================================
    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_A_DATA = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_A_DIR  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_A_PUE  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_B_DATA = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_B_DIR  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_B_PUE  = 8'h14;

    // =====================================================================
    // Field positions
    localparam int WAKE_VIEW_BIT = 6;   // Read-only wakeup view in port A data
    localparam int OSC_EN_BIT    = 7;   // Clock-out enable in port A pullup reg
    localparam int IRQ_PIN_BIT   = 2;   // Input-only pin shared with interrupt
    localparam int CLK_PIN_BIT   = 4;   // Pin that can carry the clock out

    // =====================================================================
    // Reset values
    localparam logic [PORT_A_W-1:0] DIR_A_RST = 6'h00;
    localparam logic [PORT_B_W-1:0] DIR_B_RST = 8'h00;
    localparam logic [PORT_A_W-1:0] PUE_A_RST = 6'h00;
    localparam logic [PORT_B_W-1:0] PUE_B_RST = 8'h00;
    localparam logic                OSC_EN_RST = 1'b0;

    // =====================================================================
    // Oscillator option codes
    typedef enum logic [1:0] {
        OSC_INTERNAL = 2'h0,
        OSC_EXT_CLK  = 2'h1,
        OSC_EXT_RC   = 2'h2,
        OSC_XTAL     = 2'h3
    } osc_option_t;
endpackage

// ===== hw/gpio_pin_bank.sv
// Purpose: Pin logic for one port: input synchroniser and pad drivers.
// Assumes: Pad signals are registered; one cycle after the registers change.
// Notes:   Read value is combinational: the latch for outputs, the synchronised pin level for inputs.
`timescale 1ns/1ps
module gpio_pin_bank #(
    parameter int W = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] pin_in,
    input  wire logic [W-1:0] latch,
    input  wire logic [W-1:0] dir,
    input  wire logic [W-1:0] pue,
    input  wire logic [W-1:0] drive_ok,
    input  wire logic [W-1:0] alt_en,
    input  wire logic [W-1:0] alt_val,
    output logic      [W-1:0] read_val,
    output logic      [W-1:0] pad_out,
    output logic      [W-1:0] pad_oe,
    output logic      [W-1:0] pad_pullup
);
    // =====================================================================
    // Elaboration check
    if (W < 1 || W > 8) begin : g_bad_width
        $error("gpio_pin_bank: width must be 1 to 8");
    end

    logic [W-1:0] pin_meta_ff;
    logic [W-1:0] pin_sync_ff;

    // =====================================================================
    // Per-pin logic
    for (genvar i = 0; i < W; i++) begin : g_pin
        // Two flops before any logic looks at the pad
        always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
                pin_meta_ff[i] <= 1'b0;
                pin_sync_ff[i] <= 1'b0;
            end else begin
                pin_meta_ff[i] <= pin_in[i];
                pin_sync_ff[i] <= pin_meta_ff[i];
            end
        end

        // Output pins read back the latch, inputs read the pad
        assign read_val[i] = dir[i] ? latch[i] : pin_sync_ff[i];

        // Pad drivers; a pullup is never left on against an output
        always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
                pad_out[i]    <= 1'b0;
                pad_oe[i]     <= 1'b0;
                pad_pullup[i] <= 1'b0;
            end else begin
                pad_out[i]    <= alt_en[i] ? alt_val[i] : latch[i];
                pad_oe[i]     <= alt_en[i] | (dir[i] & drive_ok[i]);
                pad_pullup[i] <= ~alt_en[i] & pue[i] & ~dir[i];
            end
        end
    end
endmodule

// ===== hw/dual_gpio_port_block.sv
// Purpose: Two general-purpose ports (six and eight pins) behind APB.
// Assumes: sys_clk 10 MHz; rst_b async active low; APB4 master.
// Notes:   Zero-wait APB: pready rises in the first access cycle.
`timescale 1ns/1ps
module dual_gpio_port_block
    import gpio_pkg::*;
(
    input  wire logic                            sys_clk,
    input  wire logic                            rst_b,
    // APB slave
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [gpio_pkg::ADDR_W-1:0]     paddr,
    input  wire logic [gpio_pkg::DATA_W-1:0]     pwdata,
    input  wire logic [3:0]                      pstrb,
    output logic                                 pready,
    output logic      [gpio_pkg::DATA_W-1:0]     prdata,
    output logic                                 pslverr,
    // System side
    input  wire logic [1:0]                      osc_option,
    input  wire logic                            irq_pin_enable,
    input  wire logic                            wakeup_request,
    input  wire logic                            quad_bus_clock,
    // Port A pads
    input  wire logic [gpio_pkg::PORT_A_W-1:0]   first_port_pin_in,
    output logic      [gpio_pkg::PORT_A_W-1:0]   first_port_pin_out,
    output logic      [gpio_pkg::PORT_A_W-1:0]   first_port_pin_oe,
    output logic      [gpio_pkg::PORT_A_W-1:0]   first_port_pullup,
    // Port B pads
    input  wire logic [gpio_pkg::PORT_B_W-1:0]   second_port_pin_in,
    output logic      [gpio_pkg::PORT_B_W-1:0]   second_port_pin_out,
    output logic      [gpio_pkg::PORT_B_W-1:0]   second_port_pin_oe,
    output logic      [gpio_pkg::PORT_B_W-1:0]   second_port_pullup
);
    import gpio_pkg::*;

    // =====================================================================
    // Register state
    logic [PORT_A_W-1:0] first_port_data_ff;
    logic [PORT_A_W-1:0] first_port_direction_ff;
    logic [PORT_A_W-1:0] first_port_pullup_enable_ff;
    logic                osc_pin_clock_out_enable_ff;
    logic [PORT_B_W-1:0] second_port_data_ff;
    logic [PORT_B_W-1:0] second_port_direction_ff;
    logic [PORT_B_W-1:0] second_port_pullup_enable_ff;
    logic                pready_ff;
    logic [DATA_W-1:0]   prdata_ff;
    logic                pslverr_ff;
    logic                qclk_meta_ff;
    logic                qclk_sync_ff;

    // =====================================================================
    // Bus decode
    wire setup_phase  = psel & ~penable;
    wire access_done  = psel & penable & pready_ff;
    wire wr_en        = access_done & pwrite & pstrb[0];
    wire hit_a_data   = (paddr == OFS_A_DATA);
    wire hit_a_dir    = (paddr == OFS_A_DIR);
    wire hit_a_pue    = (paddr == OFS_A_PUE);
    wire hit_b_data   = (paddr == OFS_B_DATA);
    wire hit_b_dir    = (paddr == OFS_B_DIR);
    wire hit_b_pue    = (paddr == OFS_B_PUE);
    wire addr_mapped  = hit_a_data | hit_a_dir | hit_a_pue
                      | hit_b_data | hit_b_dir | hit_b_pue;

    // =====================================================================
    // Clock-out selection on pin four
    wire osc_internal = (osc_option == OSC_INTERNAL) | (osc_option == OSC_EXT_RC);
    wire clk_out_on   = osc_internal & osc_pin_clock_out_enable_ff;
    wire [PORT_A_W-1:0] a_alt_en  = clk_out_on ? (PORT_A_W'(1) << CLK_PIN_BIT) : '0;
    wire [PORT_A_W-1:0] a_alt_val = qclk_sync_ff ? (PORT_A_W'(1) << CLK_PIN_BIT) : '0;
    // Bit two has no output driver at all
    wire [PORT_A_W-1:0] a_drive_ok = ~(PORT_A_W'(1) << IRQ_PIN_BIT);
    wire [PORT_B_W-1:0] b_drive_ok = '1;

    // =====================================================================
    // Read data assembly
    logic [PORT_A_W-1:0] a_read_raw;
    logic [PORT_B_W-1:0] b_read_val;
    wire  [PORT_A_W-1:0] a_irq_mask = irq_pin_enable ? ~(PORT_A_W'(1) << IRQ_PIN_BIT) : '1;
    wire  [7:0] a_data_rd = {1'b0, wakeup_request, a_read_raw & a_irq_mask};
    wire  [7:0] a_dir_rd  = {2'b00, first_port_direction_ff};
    wire  [7:0] a_pue_rd  = {osc_pin_clock_out_enable_ff, 1'b0, first_port_pullup_enable_ff};
    wire  [7:0] rd_byte   = hit_a_data ? a_data_rd
                          : hit_a_dir  ? a_dir_rd
                          : hit_a_pue  ? a_pue_rd
                          : hit_b_data ? b_read_val
                          : hit_b_dir  ? second_port_direction_ff
                          : hit_b_pue  ? second_port_pullup_enable_ff
                          : 8'h00;

    // =====================================================================
    // APB answer: ready in the first access cycle, data captured at setup
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= setup_phase;
            pslverr_ff <= setup_phase & ~addr_mapped;
            if (setup_phase) begin
                prdata_ff <= (pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte});
            end
        end
    end

    // =====================================================================
    // Data latches have no reset; software owns their contents
    always_ff @(posedge sys_clk) begin
        if (wr_en && hit_a_data) begin
            first_port_data_ff <= pwdata[PORT_A_W-1:0];
        end
        if (wr_en && hit_b_data) begin
            second_port_data_ff <= pwdata[PORT_B_W-1:0];
        end
    end

    // =====================================================================
    // Direction and pullup registers; every pin starts as an input
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            first_port_direction_ff      <= DIR_A_RST;
            second_port_direction_ff     <= DIR_B_RST;
            first_port_pullup_enable_ff  <= PUE_A_RST;
            second_port_pullup_enable_ff <= PUE_B_RST;
            osc_pin_clock_out_enable_ff  <= OSC_EN_RST;
        end else begin
            if (wr_en && hit_a_dir) begin
                first_port_direction_ff <= pwdata[PORT_A_W-1:0];
            end
            if (wr_en && hit_b_dir) begin
                second_port_direction_ff <= pwdata[PORT_B_W-1:0];
            end
            if (wr_en && hit_a_pue) begin
                first_port_pullup_enable_ff <= pwdata[PORT_A_W-1:0];
                osc_pin_clock_out_enable_ff <= pwdata[OSC_EN_BIT];
            end
            if (wr_en && hit_b_pue) begin
                second_port_pullup_enable_ff <= pwdata[PORT_B_W-1:0];
            end
        end
    end

    // =====================================================================
    // Fast clock sampled into sys_clk; it aliases, so the pin only shows a
    // level-sampled copy, a limitation of the single-clock design
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            qclk_meta_ff <= 1'b0;
            qclk_sync_ff <= 1'b0;
        end else begin
            qclk_meta_ff <= quad_bus_clock;
            qclk_sync_ff <= qclk_meta_ff;
        end
    end

    // =====================================================================
    // Pin banks
    gpio_pin_bank #(.W(PORT_A_W)) u_bank_a (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .pin_in     (first_port_pin_in),
        .latch      (first_port_data_ff),
        .dir        (first_port_direction_ff),
        .pue        (first_port_pullup_enable_ff),
        .drive_ok   (a_drive_ok),
        .alt_en     (a_alt_en),
        .alt_val    (a_alt_val),
        .read_val   (a_read_raw),
        .pad_out    (first_port_pin_out),
        .pad_oe     (first_port_pin_oe),
        .pad_pullup (first_port_pullup)
    );

    gpio_pin_bank #(.W(PORT_B_W)) u_bank_b (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .pin_in     (second_port_pin_in),
        .latch      (second_port_data_ff),
        .dir        (second_port_direction_ff),
        .pue        (second_port_pullup_enable_ff),
        .drive_ok   (b_drive_ok),
        .alt_en     ('0),
        .alt_val    ('0),
        .read_val   (b_read_val),
        .pad_out    (second_port_pin_out),
        .pad_oe     (second_port_pin_oe),
        .pad_pullup (second_port_pullup)
    );

    // Bus outputs straight from flops
    assign pready  = pready_ff;
    assign prdata  = prdata_ff;
    assign pslverr = pslverr_ff;

    // =====================================================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    property p_dir_reset;
        $rose(rst_b) |-> (first_port_direction_ff == '0) && (second_port_direction_ff == '0);
    endproperty
    a_dir_reset: assert property (p_dir_reset) else $error("Direction not cleared");

    property p_oe_follows_dir;
        1 |=> second_port_pin_oe == $past(second_port_direction_ff);
    endproperty
    a_oe_follows_dir: assert property (p_oe_follows_dir) else $error("Port B oe wrong");

    property p_bit_two_never_drives;
        !first_port_pin_oe[IRQ_PIN_BIT];
    endproperty
    a_bit_two_never_drives: assert property (p_bit_two_never_drives)
        else $error("Bit two drove");

    property p_pullup_b;
        1 |=> second_port_pullup ==
              ($past(second_port_pullup_enable_ff) & ~$past(second_port_direction_ff));
    endproperty
    a_pullup_b: assert property (p_pullup_b) else $error("Port B pullup wrong");

    property p_pullup_off_a;
        (first_port_pullup_enable_ff == '0) |=> (first_port_pullup == '0);
    endproperty
    a_pullup_off_a: assert property (p_pullup_off_a) else $error("Pullup without enable");

    property p_write_b_data;
        (wr_en && hit_b_data) |=> second_port_data_ff == $past(pwdata[PORT_B_W-1:0]);
    endproperty
    a_write_b_data: assert property (p_write_b_data) else $error("Port B write lost");

    property p_read_b_latch;
        (setup_phase && !pwrite && hit_b_data && second_port_direction_ff == 8'hff)
            |=> prdata[7:0] == $past(second_port_data_ff);
    endproperty
    a_read_b_latch: assert property (p_read_b_latch) else $error("Output read wrong");

    property p_wake_view;
        (setup_phase && !pwrite && hit_a_data) |=> prdata[WAKE_VIEW_BIT] == $past(wakeup_request)
            && prdata[7] == 1'b0;
    endproperty
    a_wake_view: assert property (p_wake_view) else $error("Wakeup view wrong");

    property p_irq_reads_zero;
        (setup_phase && !pwrite && hit_a_data && irq_pin_enable) |=> !prdata[IRQ_PIN_BIT];
    endproperty
    a_irq_reads_zero: assert property (p_irq_reads_zero) else $error("Bit two not zero");

    property p_clock_out;
        (osc_internal && osc_pin_clock_out_enable_ff) |=> first_port_pin_oe[CLK_PIN_BIT];
    endproperty
    a_clock_out: assert property (p_clock_out) else $error("Clock out not driven");

    property p_xtal_ignores;
        (osc_option == OSC_XTAL || osc_option == OSC_EXT_CLK) |=>
            first_port_pin_oe[CLK_PIN_BIT] == $past(first_port_direction_ff[CLK_PIN_BIT]);
    endproperty
    a_xtal_ignores: assert property (p_xtal_ignores) else $error("Enable not ignored");

    property p_single_access;
        setup_phase |=> pready ##1 !pready;
    endproperty
    a_single_access: assert property (p_single_access) else $error("Access not single");

    // =====================================================================
    // Pad and register checks
    property p_write_a_data;
        (wr_en && hit_a_data) |=> first_port_data_ff == $past(pwdata[PORT_A_W-1:0]);
    endproperty
    a_write_a_data: assert property (p_write_a_data) else $error("A write lost");

    property p_a_upper_zero;
        (setup_phase && !pwrite && hit_a_dir) |=> prdata[DATA_W-1:PORT_A_W] == '0;
    endproperty
    a_a_upper_zero: assert property (p_a_upper_zero) else $error("A bits set");

    property p_oe_a;
        !clk_out_on |=> first_port_pin_oe[5:3] == $past(first_port_direction_ff[5:3])
            && first_port_pin_oe[1:0] == $past(first_port_direction_ff[1:0]);
    endproperty
    a_oe_a: assert property (p_oe_a) else $error("Port A oe wrong");

    property p_pullup_not_out;
        1 |=> (first_port_pullup & $past(first_port_direction_ff)) == '0;
    endproperty
    a_pullup_not_out: assert property (p_pullup_not_out) else $error("Pullup on out");

    property p_pullup_off_b;
        (second_port_pullup_enable_ff == '0) |=> (second_port_pullup == '0);
    endproperty
    a_pullup_off_b: assert property (p_pullup_off_b) else $error("B pullup on");

    property p_clock_pin;
        clk_out_on |=> !first_port_pullup[CLK_PIN_BIT]
            && first_port_pin_out[CLK_PIN_BIT] == $past(qclk_sync_ff);
    endproperty
    a_clock_pin: assert property (p_clock_pin) else $error("Clock pin wrong");

    property p_osc_enable_write;
        (wr_en && hit_a_pue) |=> osc_pin_clock_out_enable_ff == $past(pwdata[OSC_EN_BIT]);
    endproperty
    a_osc_enable_write: assert property (p_osc_enable_write) else $error("Enable lost");

    property p_read_a_input;
        (setup_phase && !pwrite && hit_a_data && first_port_direction_ff == '0
            && !irq_pin_enable) |=> prdata[PORT_A_W-1:0] == $past(first_port_pin_in, 3);
    endproperty
    a_read_a_input: assert property (p_read_a_input) else $error("Input read wrong");

    property p_refuse_unmapped;
        (setup_phase && !addr_mapped) |=> pslverr && prdata == '0;
    endproperty
    a_refuse_unmapped: assert property (p_refuse_unmapped) else $error("No error");

    property p_oe_reset;
        $rose(rst_b) |-> (second_port_pin_oe == '0) && (first_port_pin_oe == '0);
    endproperty
    a_oe_reset: assert property (p_oe_reset) else $error("Pad driven at reset");

    c_write_a_dir: cover property (wr_en && hit_a_dir);
    c_read_input:  cover property (setup_phase && !pwrite && hit_a_data);
    c_clock_out:   cover property (clk_out_on ##1 first_port_pin_oe[CLK_PIN_BIT]);
    c_bad_addr:    cover property (access_done && pslverr);
    c_irq_masked:  cover property (setup_phase && !pwrite && hit_a_data && irq_pin_enable);
endmodule

// ===== bench/pin_board_model.sv
// Purpose: Board-side model of the pads of one port.
// Assumes: Pad outputs come from the block; the bench may drive any pin.
// Notes:   An undriven pin without pullup toggles, so stale levels show.
`timescale 1ns/1ps
module pin_board_model #(
    parameter int W = 8
) (
    input  wire logic         sys_clk,
    input  wire logic [W-1:0] pad_out,
    input  wire logic [W-1:0] pad_oe,
    input  wire logic [W-1:0] pad_pullup,
    input  wire logic [W-1:0] ext_val,
    input  wire logic [W-1:0] ext_en,
    output logic      [W-1:0] level
);
    logic [W-1:0] last_ff = '0;

    // =====================================================================
    // Wire resolution: block driver first, then board, then pullup
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (pad_oe[i]) begin
                level[i] = pad_out[i];
            end else if (ext_en[i]) begin
                level[i] = ext_val[i];
            end else if (pad_pullup[i]) begin
                level[i] = 1'b1;
            end else begin
                level[i] = ~last_ff[i];       // Floating pin never holds
            end
        end
    end

    // Remember the level so a floating pin can flip every cycle
    always @(posedge sys_clk) begin
        last_ff <= level;
    end
endmodule

// ===== bench/dual_gpio_port_block_bench.sv
// Purpose: Self-checking bench for the dual port block over APB.
// Assumes: Zero-wait slave; pads lag register writes by one cycle.
// Notes:   Pin levels pass two sync flops, so reads wait a few cycles.
`timescale 1ns/1ps
module dual_gpio_port_block_bench;
    import gpio_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  osc_option = 2'h0;
    logic        irq_pin_enable = 1'b0;
    logic        wakeup_request = 1'b0;
    logic        qclk = 1'b0;
    logic [5:0]  a_out, a_oe, a_pu, a_lvl, a_ext = 6'h00, a_en = 6'h00;
    logic [7:0]  b_out, b_oe, b_pu, b_lvl, b_ext = 8'h00, b_en = 8'h00;
    logic        last_err;
    int          num_errors = 0;
    int          compares = 0;

    // Clock at 10 MHz; the clock-out source toggles every cycle
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) qclk <= ~qclk;

    dual_gpio_port_block DUT (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .osc_option(osc_option), .irq_pin_enable(irq_pin_enable),
        .wakeup_request(wakeup_request), .quad_bus_clock(qclk),
        .first_port_pin_in(a_lvl), .first_port_pin_out(a_out),
        .first_port_pin_oe(a_oe), .first_port_pullup(a_pu),
        .second_port_pin_in(b_lvl), .second_port_pin_out(b_out),
        .second_port_pin_oe(b_oe), .second_port_pullup(b_pu));
    pin_board_model #(.W(6)) board_a (.sys_clk(sys_clk), .pad_out(a_out),
        .pad_oe(a_oe), .pad_pullup(a_pu), .ext_val(a_ext), .ext_en(a_en),
        .level(a_lvl));
    pin_board_model #(.W(8)) board_b (.sys_clk(sys_clk), .pad_out(b_out),
        .pad_oe(b_oe), .pad_pullup(b_pu), .ext_val(b_ext), .ext_en(b_en),
        .level(b_lvl));

    // =====================================================================
    // Reporting
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // =====================================================================
    // APB master: hold the request until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        // Hold the access phase until pready is seen high at a rising edge
        while (n < 20) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
            n++;
        end
        if (n == 20) begin
            num_errors++;
            complete_run();
        end
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        apb(1'b1, a, d, dummy);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] got;
        apb(1'b0, a, 32'h0, got);
        chk(nm, exp, got);
    endtask

    // Let pads and the two sync flops catch up
    task automatic settle();
        repeat (4) @(posedge sys_clk);
    endtask

    // =====================================================================
    // Main sequence
    initial begin
        logic exp_clk;
        logic prev_clk;
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(OFS_A_DIR, 32'h0, "a_dir reset");
        rd(OFS_B_DIR, 32'h0, "b_dir reset");
        rd(OFS_A_PUE, 32'h0, "a_pue reset");
        chk("oe reset", 32'h0, {a_oe, b_oe});
        // Port B output: data first, then direction, to avoid a glitch
        wr(OFS_B_DATA, 32'h5a);
        wr(OFS_B_DIR, 32'hff);
        settle();
        chk("b oe", 32'hff, {24'h0, b_oe});
        chk("b out", 32'h5a, {24'h0, b_out});
        rd(OFS_B_DATA, 32'h5a, "b data latch");
        // Port A output, bit two must stay undriven
        wr(OFS_A_DATA, 32'h3f);
        wr(OFS_A_DIR, 32'hff);
        wakeup_request <= 1'b1;
        settle();
        chk("a oe", 32'h3b, {26'h0, a_oe});
        chk("a out", 32'h3f, {26'h0, a_out});
        rd(OFS_A_DIR, 32'h3f, "a_dir width");
        rd(OFS_A_DATA, 32'h7f, "a data latch");
        // Port A input: pins read, interrupt mode masks bit two
        wr(OFS_A_DIR, 32'h00);
        a_en <= 6'h3f;
        a_ext <= 6'h15;
        settle();
        rd(OFS_A_DATA, 32'h55, "a data pins");
        irq_pin_enable <= 1'b1;
        rd(OFS_A_DATA, 32'h51, "a data irq");
        irq_pin_enable <= 1'b0;
        wakeup_request <= 1'b0;
        wr(OFS_A_DATA, 32'h00);
        rd(OFS_A_DATA, 32'h15, "a write to input");
        wr(OFS_A_DIR, 32'h3f);
        rd(OFS_A_DATA, 32'h00, "a latch kept");
        // Pullups follow enable and input direction
        wr(OFS_A_PUE, 32'h3f);
        wr(OFS_B_DIR, 32'h0f);
        wr(OFS_B_PUE, 32'hff);
        settle();
        chk("a pullup out", 32'h0, {26'h0, a_pu});
        chk("b pullup", 32'hf0, {24'h0, b_pu});
        wr(OFS_B_PUE, 32'h81);
        settle();
        chk("b pullup bits", 32'h80, {24'h0, b_pu});
        wr(OFS_B_PUE, 32'h00);
        settle();
        chk("b pullup off", 32'h0, {24'h0, b_pu});
        // Clock-out on bit four under every oscillator option
        a_en <= 6'h00;
        wr(OFS_A_DIR, 32'h00);
        wr(OFS_A_PUE, 32'h90);
        rd(OFS_A_PUE, 32'h90, "a_pue clock bit");
        for (int i = 0; i < 4; i++) begin
            osc_option <= 2'(i);
            settle();
            exp_clk = (i == 0) || (i == 2);
            chk("clk oe", {31'h0, exp_clk}, {31'h0, a_oe[4]});
            chk("clk pu", {31'h0, ~exp_clk}, {31'h0, a_pu[4]});
            if (exp_clk) begin
                prev_clk = a_out[4];
                @(posedge sys_clk);
                chk("clk toggles", {31'h0, ~prev_clk}, {31'h0, a_out[4]});
                chk("clk on pin", {31'h0, a_out[4]}, {31'h0, a_lvl[4]});
            end
        end
        osc_option <= 2'h0;
        // Unmapped word refused
        rd(8'h18, 32'h0, "unmapped data");
        chk("unmapped err", 32'h1, {31'h0, last_err});
        // Reset in mid-run keeps data but clears direction
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(OFS_B_DIR, 32'h0, "b_dir rerst");
        wr(OFS_B_DIR, 32'hff);
        rd(OFS_B_DATA, 32'h5a, "b latch kept");
        complete_run();
    end
endmodule
